// ---- inc/dsau_pkg.sv ----
// Shared constants, types and decode functions of the data space access unit.
`default_nettype none
package dsau_pkg;
   // Effective address geometry.
   localparam int ADDR_W = 16;
   localparam int NEAR_W = 13;
   localparam int PSV_BIT = 15;
   localparam int DATA_W = 16;
   // Region boundaries in byte addresses.
   localparam logic [15:0] SFR_LAST = 16'h07ff;
   localparam logic [15:0] RAM_BASE = 16'h0800;
   localparam int RAM_BYTES_DEF = 16384;
   // Values after reset.
   localparam logic [15:0] RST_WORD = 16'h0000;
   localparam logic [1:0] RST_STRB = 2'h0;
   // Pointer steps for post-increment.
   localparam logic [15:0] STEP_BYTE = 16'h0001;
   localparam logic [15:0] STEP_WORD = 16'h0002;
   // Lane strobes.
   localparam logic [1:0] STRB_LO = 2'h1;
   localparam logic [1:0] STRB_HI = 2'h2;
   localparam logic [1:0] STRB_BOTH = 2'h3;

   // Target region of one effective address.
   typedef enum logic [3:0] {
      REG_SFR = 4'h1,
      REG_RAM = 4'h2,
      REG_NONE = 4'h4,
      REG_PSV = 4'h8
   } region_e;

   // Working register update kinds.
   typedef enum logic [3:0] {
      WOP_WORD = 4'h1,
      WOP_BYTE = 4'h2,
      WOP_SIGN = 4'h4,
      WOP_ZERO = 4'h8
   } wreg_op_e;

   // Direct addressing with the short field reaches only the near space.
   function automatic logic [15:0] form_ea(input logic short_abs,
                                           input logic [15:0] a);
      form_ea = short_abs ? {3'h0, a[NEAR_W-1:0]} : a;
   endfunction : form_ea

   // Upper half goes to the visibility window; the rest is SFR, RAM or hole.
   function automatic region_e decode_region(input logic [15:0] ea,
                                             input logic [15:0] ram_end);
      if (ea[PSV_BIT])
         decode_region = REG_PSV;
      else if (ea <= SFR_LAST)
         decode_region = REG_SFR;
      else if (ea >= RAM_BASE && ea <= ram_end)
         decode_region = REG_RAM;
      else
         decode_region = REG_NONE;
   endfunction : decode_region
endpackage : dsau_pkg
`default_nettype wire

// ---- verilog/wreg_byte_merge.sv ----
// Working register merge for word, byte, sign-extend and zero-extend loads.
`default_nettype none
module wreg_byte_merge
   import dsau_pkg::*;
(
   // Operation and operands.
   input wire wreg_op_e op,
   input wire logic [15:0] old_val,
   input wire logic [15:0] new_val,
   // Merged register value.
   output logic [15:0] result
);
   // A byte load keeps the upper byte; sign extend fills it from bit 7, zero extend clears it.
   always_comb begin
      result = new_val;
      unique case (op)
         WOP_WORD: result = new_val;
         WOP_BYTE: result = {old_val[15:8], new_val[7:0]};
         WOP_SIGN: result = {{8{new_val[7]}}, new_val[7:0]};
         WOP_ZERO: result = {8'h00, new_val[7:0]};
         default: result = new_val;
      endcase
   end
endmodule : wreg_byte_merge
`default_nettype wire

// ---- verilog/data_space_access_unit.sv ----
// Data space access unit: address decode, lanes, alignment traps, W merge.
// Contract
// - Effective addresses are 16-bit byte addresses over a 64 Kbyte space.
// - Addresses with bit 15 clear hit memory; set goes to visibility window.
// - At most 16 Kbytes implemented; reads outside it return zero.
// - Read and write addresses are formed on separate independent paths.
// - Low byte of a word at even address, high byte at odd.
// - Post-increment steps pointer by one for bytes, two for words.
// - Byte read fetches the word, picks by bit 0, delivers on low lane.
// - One word decode, separate lane strobes; byte write changes one half.
// - Word access at an odd address raises an address error trap.
// - Misaligned read completes; misaligned write is suppressed; trap follows.
// - Byte load into a working register leaves its high byte unchanged.
// - Sign-extend widens 8-bit signed data; zero-extend clears high byte.
// - Special function registers occupy the lowest 2 Kbytes of data space.
// - Unused addresses inside the SFR region read as zero.
// - Short 13-bit direct field reaches low 8 Kbytes; 16-bit reaches all.
`default_nettype none
module data_space_access_unit
   import dsau_pkg::*;
#(
   parameter int RAM_BYTES = RAM_BYTES_DEF
)
(
   // Clock and reset.
   input wire logic clk,
   input wire logic rst,
   // Read address generation request.
   input wire logic rd_req,
   input wire logic rd_short,
   input wire logic rd_word,
   input wire logic [15:0] rd_addr,
   // Read answer.
   output logic rd_valid_ff,
   output logic [15:0] rd_data_ff,
   // Write address generation request.
   input wire logic wr_req,
   input wire logic wr_short,
   input wire logic wr_word,
   input wire logic [15:0] wr_addr,
   input wire logic [15:0] wr_data,
   // Special function register port.
   output logic sfr_rd_en_ff,
   output logic [15:0] sfr_rd_addr_ff,
   input wire logic sfr_rd_hit,
   input wire logic [15:0] sfr_rd_data,
   output logic sfr_wr_en_ff,
   output logic [15:0] sfr_wr_addr_ff,
   output logic [1:0] sfr_wr_strb_ff,
   output logic [15:0] sfr_wr_data_ff,
   // Program space visibility window.
   output logic psv_rd_en_ff,
   output logic [15:0] psv_rd_addr_ff,
   input wire logic [15:0] psv_rd_data,
   // Address error toward exception logic.
   output logic addr_err_ff,
   output logic addr_err_write_ff,
   // Post-increment pointer update.
   input wire logic ptr_req,
   input wire logic ptr_byte,
   input wire logic [15:0] source_pointer_register,
   output logic ptr_valid_ff,
   output logic [15:0] ptr_next_ff,
   // Working register load.
   input wire logic wreg_req,
   input wire wreg_op_e wreg_op,
   input wire logic [15:0] wreg_old,
   input wire logic [15:0] wreg_new,
   output logic wreg_valid_ff,
   output logic [15:0] wreg_result_ff
);
   localparam int AW = $clog2(RAM_BYTES / 2);
   localparam logic [15:0] RAM_END = 16'(RAM_BASE + RAM_BYTES - 1);

   logic [15:0] ram_mem [RAM_BYTES/2];
   logic [15:0] rea, wea, woff, roff, wlane, src_word, nxt_rd_data;
   logic [15:0] wreg_merged;
   region_e rreg, wreg;
   logic rmis, wmis, wcommit;
   logic [1:0] wstrb;
   logic rs_valid_ff, rs_word_ff, rd_word_q_ff;
   logic [15:0] rs_ea_ff;
   region_e rs_region_ff;

   // Separate read and write paths form both addresses in one cycle.
   assign rea = form_ea(rd_short, rd_addr);
   assign wea = form_ea(wr_short, wr_addr);
   assign rreg = decode_region(rea, RAM_END);
   assign wreg = decode_region(wea, RAM_END);
   assign roff = 16'(rs_ea_ff - RAM_BASE);
   assign woff = 16'(wea - RAM_BASE);

   // Only word accesses need alignment; bytes may sit at any address.
   assign rmis = rd_req && rd_word && rea[0];
   assign wmis = wr_req && wr_word && wea[0];
   assign wcommit = wr_req && !wmis;

   // Word writes hit both lanes; a byte write only the lane of bit 0.
   assign wstrb = wr_word ? STRB_BOTH : (wea[0] ? STRB_HI : STRB_LO);
   assign wlane = wr_word ? wr_data : {wr_data[7:0], wr_data[7:0]};

   // Read stage one latches the request; the address drives out at the same edge.
   always_ff @(posedge clk) begin
      if (rst) begin
         rs_valid_ff <= 1'b0;
         rs_word_ff <= 1'b0;
         rs_ea_ff <= RST_WORD;
         rs_region_ff <= REG_NONE;
      end else begin
         rs_valid_ff <= rd_req;
         rs_word_ff <= rd_word;
         rs_ea_ff <= rea;
         rs_region_ff <= rreg;
      end
   end

   // External read strobes; SFR and window answer in the same cycle.
   always_ff @(posedge clk) begin
      if (rst) begin
         sfr_rd_en_ff <= 1'b0;
         sfr_rd_addr_ff <= RST_WORD;
         psv_rd_en_ff <= 1'b0;
         psv_rd_addr_ff <= RST_WORD;
      end else begin
         sfr_rd_en_ff <= rd_req && rreg == REG_SFR;
         sfr_rd_addr_ff <= {rea[15:1], 1'b0};
         psv_rd_en_ff <= rd_req && rreg == REG_PSV;
         psv_rd_addr_ff <= {rea[15:1], 1'b0};
      end
   end

   // The whole containing word is fetched, then a byte is steered low.
   always_comb begin
      src_word = RST_WORD;
      unique case (rs_region_ff)
         REG_SFR: src_word = sfr_rd_hit ? sfr_rd_data : RST_WORD;
         REG_RAM: src_word = ram_mem[roff[AW:1]];
         REG_PSV: src_word = psv_rd_data;
         REG_NONE: src_word = RST_WORD;
         default: src_word = RST_WORD;
      endcase
      if (rs_word_ff)
         nxt_rd_data = src_word;
      else
         nxt_rd_data = {8'h00, rs_ea_ff[0] ? src_word[15:8] : src_word[7:0]};
   end

   // Read answer stage; a misaligned read still returns its aligned word.
   always_ff @(posedge clk) begin
      if (rst) begin
         rd_valid_ff <= 1'b0;
         rd_data_ff <= RST_WORD;
         rd_word_q_ff <= 1'b0;
      end else begin
         rd_valid_ff <= rs_valid_ff;
         rd_data_ff <= rs_valid_ff ? nxt_rd_data : RST_WORD;
         rd_word_q_ff <= rs_word_ff;
      end
   end

   // RAM lanes are written separately under one shared word index.
   always_ff @(posedge clk) begin
      if (wcommit && wreg == REG_RAM) begin
         for (int l = 0; l < 2; l++) begin
            if (wstrb[l])
               ram_mem[woff[AW:1]][l*8 +: 8] <= wlane[l*8 +: 8];
         end
      end
   end

   // SFR writes go out one cycle later; window and hole writes are dropped.
   always_ff @(posedge clk) begin
      if (rst) begin
         sfr_wr_en_ff <= 1'b0;
         sfr_wr_addr_ff <= RST_WORD;
         sfr_wr_strb_ff <= RST_STRB;
         sfr_wr_data_ff <= RST_WORD;
      end else begin
         sfr_wr_en_ff <= wcommit && wreg == REG_SFR;
         sfr_wr_addr_ff <= {wea[15:1], 1'b0};
         sfr_wr_strb_ff <= wstrb;
         sfr_wr_data_ff <= wlane;
      end
   end

   // A write cause wins when both paths misalign in the same cycle.
   always_ff @(posedge clk) begin
      if (rst) begin
         addr_err_ff <= 1'b0;
         addr_err_write_ff <= 1'b0;
      end else begin
         addr_err_ff <= rmis || wmis;
         addr_err_write_ff <= wmis;
      end
   end

   // Pointer post-increment follows the operand size.
   always_ff @(posedge clk) begin
      if (rst) begin
         ptr_valid_ff <= 1'b0;
         ptr_next_ff <= RST_WORD;
      end else begin
         ptr_valid_ff <= ptr_req;
         ptr_next_ff <= 16'(source_pointer_register +
                            (ptr_byte ? STEP_BYTE : STEP_WORD));
      end
   end

   wreg_byte_merge u_merge (
      .op(wreg_op),
      .old_val(wreg_old),
      .new_val(wreg_new),
      .result(wreg_merged)
   );

   // Working register result is held until the next load.
   always_ff @(posedge clk) begin
      if (rst) begin
         wreg_valid_ff <= 1'b0;
         wreg_result_ff <= RST_WORD;
      end else begin
         wreg_valid_ff <= wreg_req;
         if (wreg_req)
            wreg_result_ff <= wreg_merged;
      end
   end

   // Every read answers exactly two cycles after its request.
   read_latency_a: assert property (@(posedge clk) disable iff (rst)
      rd_req |-> ##2 rd_valid_ff)
      else $error("read answer missing two cycles after request");

   // Misaligned word access gives one error pulse on the next edge.
   misalign_trap_a: assert property (@(posedge clk) disable iff (rst)
      (rmis || wmis) |=> addr_err_ff && (addr_err_write_ff == $past(wmis)))
      else $error("address error not raised for odd word access");

   // No error pulse without a misaligned cause one cycle before.
   err_cause_a: assert property (@(posedge clk) disable iff (rst)
      addr_err_ff |-> $past(rmis || wmis))
      else $error("address error without misaligned access");

   // A misaligned write never reaches the SFR port.
   write_suppress_a: assert property (@(posedge clk) disable iff (rst)
      wmis |=> !sfr_wr_en_ff)
      else $error("misaligned write was not suppressed");

   // Upper half reads go to the visibility window, never the SFR port.
   psv_route_a: assert property (@(posedge clk) disable iff (rst)
      (rd_req && rea[PSV_BIT]) |=> psv_rd_en_ff && !sfr_rd_en_ff)
      else $error("upper half read not routed to window");

   // Reads into the unimplemented hole return zero.
   hole_zero_a: assert property (@(posedge clk) disable iff (rst)
      (rd_req && rreg == REG_NONE) |-> ##2 rd_data_ff == 16'h0000)
      else $error("read outside memory did not return zero");

   // Unused SFR addresses read as zero.
   sfr_unused_a: assert property (@(posedge clk) disable iff (rst)
      (rs_valid_ff && rs_region_ff == REG_SFR && !sfr_rd_hit)
      |=> rd_data_ff == 16'h0000)
      else $error("unused SFR address did not read zero");

   // Byte reads deliver on the low lane with the high lane cleared.
   byte_lane_a: assert property (@(posedge clk) disable iff (rst)
      (rd_valid_ff && !rd_word_q_ff) |-> rd_data_ff[15:8] == 8'h00)
      else $error("byte read not on low lane");

   // A byte write to SFR strobes exactly the lane of address bit 0.
   byte_strobe_a: assert property (@(posedge clk) disable iff (rst)
      (wcommit && !wr_word) |=> sfr_wr_strb_ff ==
      ($past(wea[0]) ? STRB_HI : STRB_LO))
      else $error("byte write strobe on wrong lane");

   // Pointer advances by one for bytes and by two for words.
   ptr_step_a: assert property (@(posedge clk) disable iff (rst)
      ptr_req |=> ptr_next_ff == 16'($past(source_pointer_register) +
      ($past(ptr_byte) ? 16'h0001 : 16'h0002)))
      else $error("pointer step wrong for operand size");

   // Byte load keeps the old high byte of the working register.
   wreg_keep_a: assert property (@(posedge clk) disable iff (rst)
      (wreg_req && wreg_op == WOP_BYTE)
      |=> wreg_result_ff[15:8] == $past(wreg_old[15:8]))
      else $error("byte load changed high byte");

   // Sign-extend copies bit 7 through the high byte.
   sign_ext_a: assert property (@(posedge clk) disable iff (rst)
      (wreg_req && wreg_op == WOP_SIGN)
      |=> wreg_result_ff[15:8] == {8{$past(wreg_new[7])}})
      else $error("sign extend high byte wrong");

endmodule : data_space_access_unit
`default_nettype wire

// ---- test/sfr_psv_model.sv ----
// Register space and visibility window responder for the access unit.
`default_nettype none
module sfr_psv_model (
   // Read strobes from the access unit.
   input wire logic sfr_rd_en,
   input wire logic [15:0] sfr_rd_addr,
   input wire logic psv_rd_en,
   input wire logic [15:0] psv_rd_addr,
   // Answers, valid in the strobe cycle.
   output logic sfr_rd_hit,
   output logic [15:0] sfr_rd_data,
   output logic [15:0] psv_rd_data
);
   timeunit 1ns;
   timeprecision 1ns;

   // Only the lowest 256 bytes hold registers; the rest are unused.
   // A miss still drives junk, so a unit that ignores the hit flag shows it.
   always_comb begin
      sfr_rd_hit = sfr_rd_en && (sfr_rd_addr < 16'h0100);
      sfr_rd_data = sfr_rd_en ? (sfr_rd_addr ^ 16'h5a00) : ~sfr_rd_addr;
      psv_rd_data = psv_rd_en ? (psv_rd_addr ^ 16'h3c3c) : ~psv_rd_addr;
   end
endmodule : sfr_psv_model
`default_nettype wire

// ---- test/data_space_access_unit_test.sv ----
// Self-checking bench of the data space access unit.
`default_nettype none
module data_space_access_unit_test;
   import dsau_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   // A small RAM keeps the hole above it close at hand.
   localparam int RAMB = 256;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic rd_req = 1'b0, rd_short = 1'b0, rd_word = 1'b0;
   logic wr_req = 1'b0, wr_short = 1'b0, wr_word = 1'b0;
   logic ptr_req = 1'b0, ptr_byte = 1'b0, wreg_req = 1'b0;
   logic [15:0] rd_addr = 16'h0, wr_addr = 16'h0, wr_data = 16'h0;
   logic [15:0] source_pointer_register = 16'h0;
   logic [15:0] wreg_old = 16'h0, wreg_new = 16'h0;
   wreg_op_e wreg_op = WOP_WORD;
   logic rd_valid_ff, sfr_rd_en_ff, sfr_rd_hit, sfr_wr_en_ff;
   logic psv_rd_en_ff, addr_err_ff, addr_err_write_ff;
   logic ptr_valid_ff, wreg_valid_ff, seen_en;
   logic [1:0] sfr_wr_strb_ff, err, werr, seen_strb;
   logic [15:0] rd_data_ff, sfr_rd_addr_ff, sfr_rd_data, sfr_wr_addr_ff;
   logic [15:0] sfr_wr_data_ff, psv_rd_addr_ff, psv_rd_data, ptr_next_ff;
   logic [15:0] wreg_result_ff, seen_data, seen_addr;
   int fails = 0;
   int compares = 0;

   data_space_access_unit #(.RAM_BYTES(RAMB)) dut (.clk, .rst, .rd_req,
      .rd_short, .rd_word, .rd_addr, .rd_valid_ff, .rd_data_ff, .wr_req,
      .wr_short, .wr_word, .wr_addr, .wr_data, .sfr_rd_en_ff,
      .sfr_rd_addr_ff, .sfr_rd_hit, .sfr_rd_data, .sfr_wr_en_ff,
      .sfr_wr_addr_ff, .sfr_wr_strb_ff, .sfr_wr_data_ff, .psv_rd_en_ff,
      .psv_rd_addr_ff, .psv_rd_data, .addr_err_ff, .addr_err_write_ff,
      .ptr_req, .ptr_byte, .source_pointer_register, .ptr_valid_ff,
      .ptr_next_ff, .wreg_req, .wreg_op, .wreg_old, .wreg_new,
      .wreg_valid_ff, .wreg_result_ff);

   sfr_psv_model far (.sfr_rd_en(sfr_rd_en_ff), .sfr_rd_addr(sfr_rd_addr_ff),
      .psv_rd_en(psv_rd_en_ff), .psv_rd_addr(psv_rd_addr_ff),
      .sfr_rd_hit(sfr_rd_hit), .sfr_rd_data(sfr_rd_data),
      .psv_rd_data(psv_rd_data));

   // 50 ns period.
   initial forever #25 clk = ~clk;

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic finish_test();
      if (fails == 0 && compares > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : finish_test

   // One read; the error pulse is gathered over the whole latency.
   task automatic rd(input logic s, w, input logic [15:0] a,
                     output logic [15:0] d);
      int n;
      @(posedge clk);
      rd_req <= 1'b1;
      rd_short <= s;
      rd_word <= w;
      rd_addr <= a;
      @(posedge clk);
      rd_req <= 1'b0;
      err = 2'h0;
      for (n = 0; n < 5; n++) begin
         #1;
         err = err | {addr_err_ff, addr_err_write_ff};
         if (rd_valid_ff === 1'b1)
            break;
         @(posedge clk);
      end
      chk({15'h0, n < 5}, 16'h0001);
      d = rd_data_ff;
   endtask : rd

   // One write; captures the register strobe or the error, if any comes.
   task automatic wr(input logic s, w, input logic [15:0] a, dat);
      @(posedge clk);
      wr_req <= 1'b1;
      wr_short <= s;
      wr_word <= w;
      wr_addr <= a;
      wr_data <= dat;
      @(posedge clk);
      wr_req <= 1'b0;
      seen_en = 1'b0;
      werr = 2'h0;
      for (int n = 0; n < 3; n++) begin
         #1;
         if (sfr_wr_en_ff === 1'b1 || addr_err_ff === 1'b1) begin
            seen_en = sfr_wr_en_ff;
            werr = {addr_err_ff, addr_err_write_ff};
            seen_strb = sfr_wr_strb_ff;
            seen_data = sfr_wr_data_ff;
            seen_addr = sfr_wr_addr_ff;
            break;
         end
         @(posedge clk);
      end
   endtask : wr

   // RAM lanes, byte merge, last word, hole and parallel paths.
   task automatic t_ram();
      logic [15:0] d;
      wr(1'b0, 1'b1, 16'h0800, 16'h1234);
      wr(1'b0, 1'b1, 16'h08fe, 16'hbeef);
      rd(1'b0, 1'b0, 16'h0800, d);
      chk(d, 16'h0034);
      rd(1'b0, 1'b0, 16'h0801, d);
      chk(d, 16'h0012);
      wr(1'b0, 1'b0, 16'h0801, 16'h77ab);
      chk({14'h0, werr}, 16'h0000);
      rd(1'b0, 1'b1, 16'h0800, d);
      chk(d, 16'hab34);
      rd(1'b0, 1'b1, 16'h08fe, d);
      chk(d, 16'hbeef);
      rd(1'b0, 1'b1, 16'h0900, d);
      chk(d, 16'h0000);
      fork
         wr(1'b0, 1'b1, 16'h0810, 16'h4321);
         rd(1'b0, 1'b1, 16'h0800, d);
      join
      chk(d, 16'hab34);
      rd(1'b0, 1'b1, 16'h0810, d);
      chk(d, 16'h4321);
   endtask : t_ram

   // Odd word accesses: write dropped, read completes, one-cycle trap.
   task automatic t_align();
      logic [15:0] d;
      wr(1'b0, 1'b1, 16'h0802, 16'h1111);
      wr(1'b0, 1'b1, 16'h0803, 16'h5555);
      chk({14'h0, werr}, 16'h0003);
      rd(1'b0, 1'b1, 16'h0802, d);
      chk(d, 16'h1111);
      rd(1'b0, 1'b1, 16'h0803, d);
      chk({14'h0, err}, 16'h0002);
      chk(d, 16'h1111);
      chk({15'h0, addr_err_ff}, 16'h0000);
      wr(1'b0, 1'b1, 16'h0021, 16'h6666);
      chk({13'h0, werr, seen_en}, 16'h0006);
      // An even byte write must touch the low lane only.
      wr(1'b0, 1'b0, 16'h0802, 16'hff9e);
      rd(1'b0, 1'b1, 16'h0802, d);
      chk(d, 16'h119e);
   endtask : t_align

   // Window, hole, register space, unused registers and short field.
   task automatic t_space();
      logic [15:0] d;
      rd(1'b0, 1'b1, 16'h8006, d);
      chk(d, 16'hbc3a);
      rd(1'b0, 1'b1, 16'h4000, d);
      chk(d, 16'h0000);
      rd(1'b0, 1'b1, 16'h0010, d);
      chk(d, 16'h5a10);
      rd(1'b0, 1'b0, 16'h0011, d);
      chk(d, 16'h005a);
      rd(1'b0, 1'b1, 16'h0400, d);
      chk(d, 16'h0000);
      rd(1'b1, 1'b1, 16'he800, d);
      chk(d, 16'hab34);
      wr(1'b1, 1'b0, 16'he011, 16'h00c3);
      chk({13'h0, seen_en, seen_strb}, 16'h0006);
      chk(seen_data, 16'hc3c3);
      chk(seen_addr, 16'h0010);
      wr(1'b0, 1'b1, 16'h0020, 16'h9abc);
      chk({13'h0, seen_en, seen_strb}, 16'h0007);
      chk(seen_data, 16'h9abc);
      chk(seen_addr, 16'h0020);
      wr(1'b0, 1'b0, 16'h0012, 16'h0055);
      chk({13'h0, seen_en, seen_strb}, 16'h0005);
      chk(seen_data, 16'h5555);
      chk(seen_addr, 16'h0012);
   endtask : t_space

   // Pointer steps and register loads side by side, one cycle answers.
   task automatic t_regs();
      logic [4:0] pb = 5'h19;
      logic [15:0] pv [5] = '{16'h10, 16'h10, 16'hffff, 16'hffff, 16'h7fff};
      logic [15:0] pe [5] = '{16'h11, 16'h12, 16'h1, 16'h0, 16'h8000};
      wreg_op_e ops [5] = '{WOP_WORD, WOP_BYTE, WOP_SIGN, WOP_ZERO, WOP_SIGN};
      logic [15:0] nv [5] = '{16'h12f0, 16'h12f0, 16'h12f0, 16'h12f0,
                              16'h1270};
      logic [15:0] we [5] = '{16'h12f0, 16'habf0, 16'hfff0, 16'h00f0,
                              16'h0070};
      for (int i = 0; i < 5; i++) begin
         @(posedge clk);
         ptr_req <= 1'b1;
         ptr_byte <= pb[i];
         source_pointer_register <= pv[i];
         wreg_req <= 1'b1;
         wreg_op <= ops[i];
         wreg_old <= 16'habcd;
         wreg_new <= nv[i];
         @(posedge clk);
         ptr_req <= 1'b0;
         wreg_req <= 1'b0;
         #1;
         chk({14'h0, ptr_valid_ff, wreg_valid_ff}, 16'h0003);
         chk(ptr_next_ff, pe[i]);
         chk(wreg_result_ff, we[i]);
      end
   endtask : t_regs

   // Reset for eight cycles, then walk the scenarios.
   initial begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      t_ram();
      t_align();
      t_space();
      t_regs();
      finish_test();
   end
endmodule : data_space_access_unit_test
`default_nettype wire
